// ---- rtl/core_memory_slave.sv ----
// Memory board end: decodes, runs core cycles and answers the handshake.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1: Master sets lines 150ns before sync.
// RULE2: Foreign address blocks sync, no access.
// RULE3: Selection sets busy; refuse commands meanwhile.
// RULE4: Read: drive data with slave sync.
// RULE5: Master waits 75ns, captures, drops sync.
// RULE6: Drop slave sync after master sync drops.
// RULE7: Master holds lines 75ns after sync.
// RULE8: Defer early sync until busy clears.
// RULE9: Write: slave sync after latching data.
// RULE10: Start needs idle, selected, slave sync clear.
// RULE11: Shared 16 data lines; memory drives reads.
// RULE12: Bit0 byte, bits1-14 word, 15-17 block.
// RULE13: Power low inhibits starting operations.
// RULE14: Decode read-restore, read-pause, word clear-write.
// RULE15: Both low: byte write, bit0 picks byte.
// RULE16: All bus lines are active low.
// RULE17: Master follows read-pause with write.
// RULE18: Read-restore senses, presents, rewrites location.
// RULE19: Read-pause: read half only, then pause.
// RULE20: Clear-write: unsensed clear, latch, write.
// RULE21: Write after pause skips clear half.
// RULE22: Byte write loads one byte only.
// RULE23: Post-pause write: early sync, clear pause.
module core_memory_slave #(
    parameter logic [2:0] BLOCK_SELECT = core_bus_pkg::RESET_BLOCK,
    parameter int DEPTH = 16384
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Bus side.
    core_bus_if.memory bus,
    // Status.
    output logic memory_cycle_busy,
    output logic memory_selected
);
    import core_bus_pkg::*;

    typedef enum {S_IDLE, S_READ, S_SYNC, S_WRITE} sstate_type;
    typedef struct packed
    {
        sstate_type st;
        logic [WORD_ADDR_WIDTH-1:0] waddr;
        logic [1:0] cmd;
        logic byte_hi_write;
        word_type dreg;
        logic paused;
        logic ssync;
        logic drive;
        logic busy;
        logic selected;
        logic late_data;
    } slave_state_type;
    slave_state_type s;
    slave_state_type n;
    word_type core_array [DEPTH];

    initial
    begin
        if (DEPTH != (1 << WORD_ADDR_WIDTH))
        begin
            $error("core_memory_slave needs DEPTH equal to the 16K block size.");
        end
    end

    addr_type addr;
    word_type bus_data;
    logic [1:0] cmd_lvl;
    logic msync;
    logic in_block;
    logic timer_done;
    logic timer_load;
    logic [3:0] timer_count;
    word_type sensed;
    logic [WORD_ADDR_WIDTH-1:0] bus_waddr;

    // Invert the address, data and master sync lines once so the rest works in true sense; commands stay as levels.
    assign addr = ~bus.addr_n; // RULE16
    assign bus_data = ~bus.data_n;
    assign cmd_lvl = {bus.command_line_one_n, bus.command_line_zero_n};
    assign msync = ~bus.master_sync_n;
    assign bus_waddr = addr[WORD_LSB +: WORD_ADDR_WIDTH]; // RULE12
    assign in_block = addr[BLOCK_LSB +: BLOCK_WIDTH] == BLOCK_SELECT; // RULE2
    assign sensed = core_array[s.waddr];

    // Half-cycle pacing shares one timer.
    core_delay_timer #(.WIDTH(4)) half_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(timer_load),
        .count(timer_count),
        .done(timer_done)
    );

    // Cycle control; busy stays set through the write half even after the bus is freed.
    always_comb
    begin
        n = s;
        timer_load = 1'b0;
        timer_count = 4'(READ_HALF_CYCLES);
        if (s.ssync && !msync)
        begin
            n.ssync = 1'b0; // RULE6
            n.drive = 1'b0;
        end
        case (s.st)
            S_IDLE:
            begin
                n.busy = 1'b0;
                n.selected = 1'b0;
                // Sync arriving early simply waits here until all conditions hold.
                if (msync && in_block && !s.ssync && bus.supply_power_low_n) // RULE10 RULE8 RULE13
                begin
                    n.busy = 1'b1; // RULE3
                    n.selected = 1'b1;
                    n.waddr = bus_waddr;
                    n.cmd = cmd_lvl; // RULE14
                    n.byte_hi_write = ~addr[BYTE_SEL_BIT]; // RULE15
                    timer_load = 1'b1;
                    if (s.paused)
                    begin
                        n.paused = 1'b0; // RULE23 RULE21
                        n.ssync = 1'b1;
                        n.late_data = 1'b1;
                        timer_count = 4'(WRITE_HALF_CYCLES);
                        n.st = S_WRITE;
                    end
                    else
                    begin
                        n.dreg = '0;
                        n.st = S_READ;
                    end
                end
            end
            S_READ:
            begin
                if (timer_done)
                begin
                    if (s.cmd[1])
                    begin
                        n.dreg = sensed; // RULE18 RULE19
                        n.drive = 1'b1; // RULE4 RULE11
                        n.ssync = 1'b1;
                    end
                    n.st = S_SYNC;
                end
            end
            S_SYNC:
            begin
                timer_load = 1'b1;
                timer_count = 4'(WRITE_HALF_CYCLES);
                n.st = S_WRITE;
                if (s.cmd == CMD_READ_PAUSE)
                begin
                    n.paused = 1'b1; // RULE19
                    timer_load = 1'b0;
                    n.st = S_IDLE;
                end
                else if (s.cmd == CMD_CLEAR_WRITE)
                begin
                    n.dreg = bus_data; // RULE20
                    n.ssync = 1'b1; // RULE9
                end
                else if (s.cmd == CMD_BYTE_WRITE)
                begin
                    // Keep the sensed byte internally, never on the lines.
                    n.dreg = s.byte_hi_write ? {bus_data[15:8], sensed[7:0]} :
                             {sensed[15:8], bus_data[7:0]}; // RULE22
                    n.ssync = 1'b1; // RULE9
                end
            end
            S_WRITE:
            begin
                // Post-pause data is taken only while master sync stands: the master
                // frees the lines long before the write half ends, and a deferred
                // request arriving later must not overwrite the word.
                if (s.late_data)
                begin
                    n.late_data = msync;
                    if (msync && s.cmd == CMD_CLEAR_WRITE)
                    begin
                        n.dreg = bus_data; // RULE21
                    end
                    else if (msync && s.cmd == CMD_BYTE_WRITE)
                    begin
                        n.dreg = s.byte_hi_write ? {bus_data[15:8], s.dreg[7:0]} :
                                 {s.dreg[15:8], bus_data[7:0]}; // RULE22
                    end
                end
                if (timer_done)
                begin
                    n.late_data = 1'b0;
                    n.st = S_IDLE;
                end
            end
            default:
            begin
                n.st = S_IDLE;
            end
        endcase
    end

    // Register stage.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '{st: S_IDLE, waddr: '0, cmd: 2'h3, byte_hi_write: 1'b0,
                   dreg: '0, paused: 1'b0, ssync: 1'b0, drive: 1'b0, busy: 1'b0,
                   selected: 1'b0, late_data: 1'b0};
        end
        else
        begin
            s <= n;
        end
    end

    // Core store; the data registers are written back at cycle completion.
    always_ff @(posedge sys_clk)
    begin
        if (s.st == S_WRITE && timer_done)
        begin
            core_array[s.waddr] <= s.dreg; // RULE18 RULE20
        end
    end

    assign bus.slave_sync_n = ~s.ssync;
    assign bus.data_s_out_n = ~s.dreg;
    assign bus.data_s_oe_n = ~s.drive;
    assign memory_cycle_busy = s.busy;
    assign memory_selected = s.selected;
endmodule
`default_nettype wire

// ---- rtl/core_bus_pkg.sv ----
// Shared constants and types for the memory board bus handshake.
package core_bus_pkg;
    localparam int DATA_WIDTH = 16;
    localparam int ADDR_WIDTH = 18;
    localparam int WORD_ADDR_WIDTH = 14;
    localparam int BLOCK_WIDTH = 3;
    localparam int BYTE_SEL_BIT = 0;
    localparam int WORD_LSB = 1;
    localparam int BLOCK_LSB = 15;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETUP_NS = 150;
    localparam int SKEW_NS = 75;
    localparam int HOLD_NS = 75;
    localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SKEW_CYCLES = (SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_HALF_CYCLES = 6;
    localparam int WRITE_HALF_CYCLES = 6;
    localparam logic [2:0] RESET_BLOCK = 3'h0;
    // Command line pairs as levels {command_line_one, command_line_zero}, high = inactive.
    localparam logic [1:0] CMD_READ_RESTORE = 2'h3;
    localparam logic [1:0] CMD_READ_PAUSE = 2'h2;
    localparam logic [1:0] CMD_CLEAR_WRITE = 2'h1;
    localparam logic [1:0] CMD_BYTE_WRITE = 2'h0;
    typedef logic [DATA_WIDTH-1:0] word_type;
    typedef logic [ADDR_WIDTH-1:0] addr_type;
endpackage

// ---- rtl/core_bus_if.sv ----
// Interface joining the bus master and the memory board.
`timescale 1ns/10ps
`default_nettype none
interface core_bus_if;
    import core_bus_pkg::*;
    // All lines active low; an enable low means that end drives.
    addr_type addr_n;
    logic command_line_zero_n;
    logic command_line_one_n;
    logic master_sync_n;
    logic slave_sync_n;
    logic supply_power_low_n;
    word_type data_m_out_n;
    logic data_m_oe_n;
    word_type data_s_out_n;
    logic data_s_oe_n;
    word_type data_n;
    // Wired bus: released lines float high.
    assign data_n = (!data_m_oe_n) ? data_m_out_n :
                    (!data_s_oe_n) ? data_s_out_n : {DATA_WIDTH{1'b1}};
    modport master (output addr_n, command_line_zero_n, command_line_one_n, master_sync_n,
                    data_m_out_n, data_m_oe_n, input slave_sync_n, data_n);
    modport memory (input addr_n, command_line_zero_n, command_line_one_n, master_sync_n,
                    supply_power_low_n, data_n, output slave_sync_n, data_s_out_n, data_s_oe_n);
endinterface
`default_nettype wire

// ---- rtl/core_delay_timer.sv ----
// Down counter that pulses done when a loaded count has elapsed.
`timescale 1ns/10ps
`default_nettype none
module core_delay_timer #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Control.
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic done
);
    typedef struct packed
    {
        logic [WIDTH-1:0] remain;
        logic running;
        logic done;
    } timer_state_type;
    timer_state_type state;
    timer_state_type next_state;

    initial
    begin
        if (WIDTH < 2)
        begin
            $error("core_delay_timer needs WIDTH of at least 2.");
        end
    end

    // Load restarts the count; done pulses one cycle after it reaches one.
    always_comb
    begin
        next_state = state;
        next_state.done = 1'b0;
        if (load)
        begin
            next_state.remain = count;
            next_state.running = 1'b1;
        end
        else if (state.running)
        begin
            if (state.remain <= WIDTH'(1))
            begin
                next_state.running = 1'b0;
                next_state.done = 1'b1;
            end
            else
            begin
                next_state.remain = state.remain - WIDTH'(1);
            end
        end
    end

    // Register stage.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign done = state.done;
endmodule
`default_nettype wire

// ---- rtl/core_bus_master.sv ----
// Bus master end: drives address, command and data, and paces the handshake.
`timescale 1ns/10ps
`default_nettype none
module core_bus_master (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Bus side.
    core_bus_if.master bus,
    // User request.
    input wire logic req_valid,
    input wire logic [1:0] req_cmd,
    input wire core_bus_pkg::addr_type req_addr,
    input wire core_bus_pkg::word_type req_wdata,
    // User answer.
    output logic req_ready,
    output logic rsp_valid,
    output core_bus_pkg::word_type rsp_rdata
);
    import core_bus_pkg::*;

    typedef enum {M_IDLE, M_SETUP, M_WAIT, M_SKEW, M_HOLD} mstate_type;
    typedef struct packed
    {
        mstate_type st;
        logic [3:0] cnt;
        addr_type addr_n;
        logic [1:0] cmd_n;
        logic msync_n;
        word_type wdata_n;
        logic doe_n;
        logic ready;
        logic rvalid;
        word_type rdata;
        logic is_read;
    } master_state_type;
    master_state_type s;
    master_state_type n;

    // Sequencer: set up lines, raise sync, wait for reply, release after hold.
    always_comb
    begin
        n = s;
        n.rvalid = 1'b0;
        case (s.st)
            M_IDLE:
            begin
                if (req_valid && s.ready)
                begin
                    n.addr_n = ~req_addr; // RULE16
                    n.cmd_n = req_cmd;
                    n.is_read = req_cmd[1];
                    n.wdata_n = ~req_wdata;
                    n.doe_n = req_cmd[1]; // RULE11
                    n.ready = 1'b0;
                    n.cnt = 4'(SETUP_CYCLES);
                    n.st = M_SETUP;
                end
            end
            M_SETUP:
            begin
                if (s.cnt <= 4'h1)
                begin
                    n.msync_n = 1'b0; // RULE1
                    n.st = M_WAIT;
                end
                else
                begin
                    n.cnt = s.cnt - 4'h1;
                end
            end
            M_WAIT:
            begin
                if (!bus.slave_sync_n)
                begin
                    n.cnt = 4'(SKEW_CYCLES);
                    n.st = M_SKEW;
                end
            end
            M_SKEW:
            begin
                if (s.cnt <= 4'h1)
                begin
                    n.rdata = ~bus.data_n; // RULE5
                    n.rvalid = 1'b1;
                    n.msync_n = 1'b1;
                    n.cnt = 4'(HOLD_CYCLES);
                    n.st = M_HOLD;
                end
                else
                begin
                    n.cnt = s.cnt - 4'h1;
                end
            end
            M_HOLD:
            begin
                if (s.cnt <= 4'h1)
                begin
                    n.addr_n = '1; // RULE7
                    n.cmd_n = 2'h3;
                    n.doe_n = 1'b1;
                    n.ready = 1'b1;
                    n.st = M_IDLE;
                end
                else
                begin
                    n.cnt = s.cnt - 4'h1;
                end
            end
            default:
            begin
                n.st = M_IDLE;
            end
        endcase
    end

    // Register stage; all bus lines idle high after reset.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '{st: M_IDLE, cnt: 4'h0, addr_n: '1, cmd_n: 2'h3, msync_n: 1'b1,
                   wdata_n: '1, doe_n: 1'b1, ready: 1'b1, rvalid: 1'b0, rdata: '0,
                   is_read: 1'b0};
        end
        else
        begin
            s <= n;
        end
    end

    assign bus.addr_n = s.addr_n;
    assign bus.command_line_zero_n = s.cmd_n[0];
    assign bus.command_line_one_n = s.cmd_n[1];
    assign bus.master_sync_n = s.msync_n;
    assign bus.data_m_out_n = s.wdata_n;
    assign bus.data_m_oe_n = s.doe_n;
    assign req_ready = s.ready;
    assign rsp_valid = s.rvalid;
    assign rsp_rdata = s.rdata;
endmodule
`default_nettype wire

// ---- bench/core_bus_assertions.sv ----
// Concurrent checks on the bus that joins the master end and the memory end.
`timescale 1ns/10ps
`default_nettype none
module core_bus_assertions #(
    parameter logic [2:0] BLOCK_SELECT = 3'h0
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Bus lines, all active low.
    input wire core_bus_pkg::addr_type addr_n,
    input wire logic command_line_zero_n,
    input wire logic command_line_one_n,
    input wire logic master_sync_n,
    input wire logic slave_sync_n,
    input wire logic data_m_oe_n,
    input wire logic data_s_oe_n,
    // Memory status.
    input wire logic memory_cycle_busy,
    input wire logic memory_selected
);
    import core_bus_pkg::*;

    default clocking main_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Steps of one handshake, shared by the properties below.
    sequence lines_steady;
        $stable(addr_n) && $stable(command_line_zero_n) && $stable(command_line_one_n);
    endsequence
    sequence sync_held_two;
        !master_sync_n ##1 !master_sync_n;
    endsequence

    // The address lines settle at least two samples before the master raises its sync.
    setup_order_a: assert property (
        $fell(master_sync_n) |-> $past(addr_n, 2) == addr_n)
        else $error("address changed too close to master sync");
    start_cause_a: assert property (
        $rose(memory_cycle_busy) |-> !$past(master_sync_n) && $past(slave_sync_n)
            && (~addr_n[17:15] == BLOCK_SELECT))
        else $error("memory cycle began without a valid start");
    busy_answer_a: assert property (
        $fell(slave_sync_n) |-> memory_cycle_busy)
        else $error("slave sync while not busy");
    read_drive_a: assert property (
        $fell(data_s_oe_n) |-> ##[0:1] (!slave_sync_n && command_line_one_n))
        else $error("memory drove data outside a read answer");
    read_wait_a: assert property (
        $fell(slave_sync_n) |-> sync_held_two)
        else $error("master dropped sync too soon");
    sync_release_a: assert property (
        $rose(master_sync_n) |-> ##[0:2] slave_sync_n)
        else $error("slave sync not released");
    line_hold_a: assert property (
        $rose(master_sync_n) |=> lines_steady)
        else $error("lines released too soon after sync");
    answer_bound_a: assert property (
        $fell(master_sync_n) |-> ##[1:40] !slave_sync_n)
        else $error("deferred request never answered");
    write_latch_a: assert property (
        $fell(slave_sync_n) && !command_line_one_n |-> !data_m_oe_n)
        else $error("write answered without bus data");
    no_fight_a: assert property (
        !(!data_s_oe_n && !data_m_oe_n))
        else $error("both ends drive the data lines");
    select_block_a: assert property (
        $rose(memory_selected) |-> (~addr_n[17:15] == BLOCK_SELECT))
        else $error("memory selected by a foreign block");
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench: both bus ends joined, plus a bare memory end driven by hand.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import core_bus_pkg::*;
    localparam int BOUND = 60;
    localparam addr_type ADDR_W = 18'h00124;
    localparam addr_type ADDR_X = 18'h04124;
    localparam addr_type ADDR_F = 18'h08124;
    logic sys_clk;
    logic rst;
    logic req_valid;
    logic [1:0] req_cmd;
    addr_type req_addr;
    word_type req_wdata;
    logic req_ready;
    logic rsp_valid;
    word_type rsp_rdata;
    logic busy_a;
    logic sel_a;
    logic busy_b;
    logic sel_b;
    word_type wire_data;
    addr_type wire_addr;
    int mismatches;
    int total_checks;

    core_bus_if bus_a();
    core_bus_if bus_b();

    core_bus_master core_bus_master_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus_a.master),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    core_memory_slave core_memory_slave_inst (.sys_clk(sys_clk), .rst(rst),
        .bus(bus_a.memory), .memory_cycle_busy(busy_a), .memory_selected(sel_a));
    core_memory_slave core_memory_slave_inst_b (.sys_clk(sys_clk), .rst(rst),
        .bus(bus_b.memory), .memory_cycle_busy(busy_b), .memory_selected(sel_b));
    core_bus_assertions #(.BLOCK_SELECT(3'h0)) core_bus_assertions_inst (.sys_clk(sys_clk),
        .rst(rst), .addr_n(bus_a.addr_n), .command_line_zero_n(bus_a.command_line_zero_n),
        .command_line_one_n(bus_a.command_line_one_n), .master_sync_n(bus_a.master_sync_n),
        .slave_sync_n(bus_a.slave_sync_n), .data_m_oe_n(bus_a.data_m_oe_n),
        .data_s_oe_n(bus_a.data_s_oe_n), .memory_cycle_busy(busy_a),
        .memory_selected(sel_a));

    // Free-running clock at a 50 ns period.
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    // Keep what the wire carried, so the active-low sense is judged on the lines.
    always @(posedge sys_clk)
    begin
        if (!bus_a.data_s_oe_n)
            wire_data <= bus_a.data_n;
        if (!bus_a.master_sync_n)
            wire_addr <= bus_a.addr_n;
    end

    task automatic wrap_up();
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check_word(input string what, input word_type exp, input word_type got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Steps one cycle; a wait that runs past its bound ends the run.
    task automatic tick(inout int n, input string what);
        @(posedge sys_clk);
        #1;
        n++;
        if (n > BOUND)
        begin
            check_bit(what, 1'b1, 1'b0);
            wrap_up();
        end
    endtask

    // One transfer through the master end; the request stands until it is taken.
    task automatic bus_op(input logic [1:0] cmd, input addr_type addr, input word_type wdata,
                          output word_type rdata);
        int n;
        n = 0;
        req_cmd = cmd;
        req_addr = addr;
        req_wdata = wdata;
        req_valid = 1'b1;
        while (req_ready !== 1'b1)
            tick(n, "request taken");
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1)
            tick(n, "answer seen");
        rdata = rsp_rdata;
    endtask

    task automatic read_check(input logic [1:0] cmd, input addr_type addr, input word_type exp);
        word_type rd;
        bus_op(cmd, addr, 16'h0000, rd);
        check_word("read data", exp, rd);
        check_word("data lines", ~exp, wire_data);
        check_bit("address lines", 1'b1, wire_addr === ~addr);
    endtask

    // Hand-driven master on the second bus: lines first, sync three cycles later.
    task automatic b_start(input addr_type addr, input logic [1:0] cmd);
        bus_b.addr_n = ~addr;
        bus_b.command_line_one_n = cmd[1];
        bus_b.command_line_zero_n = cmd[0];
        bus_b.data_m_out_n = ~16'h0F0F;
        bus_b.data_m_oe_n = cmd[1];
        repeat (3) @(posedge sys_clk);
        #1;
        bus_b.master_sync_n = 1'b0;
    endtask

    task automatic b_stop();
        bus_b.master_sync_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        bus_b.addr_n = '1;
        bus_b.command_line_one_n = 1'b1;
        bus_b.command_line_zero_n = 1'b1;
        bus_b.data_m_oe_n = 1'b1;
    endtask

    task automatic b_silent(input string what);
        logic quiet;
        quiet = 1'b1;
        repeat (30)
        begin
            @(posedge sys_clk);
            #1;
            if (bus_b.slave_sync_n !== 1'b1 || sel_b !== 1'b0)
                quiet = 1'b0;
        end
        check_bit(what, 1'b1, quiet);
    endtask

    initial
    begin
        word_type rd;
        int n;
        mismatches = 0;
        total_checks = 0;
        rst = 1'b1;
        req_valid = 1'b0;
        req_cmd = CMD_READ_RESTORE;
        req_addr = '0;
        req_wdata = '0;
        bus_a.supply_power_low_n = 1'b1;
        bus_b.supply_power_low_n = 1'b1;
        bus_b.master_sync_n = 1'b1;
        bus_b.data_m_out_n = '1;
        b_stop();
        // The idle setup above already spent two of the five reset cycles.
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        // Word and byte writes and reads; each request queues behind the previous cycle.
        bus_op(CMD_CLEAR_WRITE, ADDR_W, 16'h5A3C, rd);
        read_check(CMD_READ_RESTORE, ADDR_W, 16'h5A3C);
        check_bit("busy after read", 1'b1, busy_a);
        read_check(CMD_READ_RESTORE, ADDR_W, 16'h5A3C);
        bus_op(CMD_BYTE_WRITE, ADDR_W | 18'h00001, 16'hC3C3, rd);
        read_check(CMD_READ_RESTORE, ADDR_W, 16'h5AC3);
        bus_op(CMD_BYTE_WRITE, ADDR_W, 16'h9600, rd);
        read_check(CMD_READ_RESTORE, ADDR_W, 16'h96C3);
        // Read-pause followed by word and by byte writes to the same place.
        read_check(CMD_READ_PAUSE, ADDR_W, 16'h96C3);
        bus_op(CMD_CLEAR_WRITE, ADDR_W, 16'h1234, rd);
        read_check(CMD_READ_RESTORE, ADDR_W, 16'h1234);
        read_check(CMD_READ_PAUSE, ADDR_W, 16'h1234);
        bus_op(CMD_BYTE_WRITE, ADDR_W, 16'hAB00, rd);
        read_check(CMD_READ_RESTORE, ADDR_W, 16'hAB34);
        // A second word apart by the top word bit; the byte bit is ignored on reads.
        bus_op(CMD_CLEAR_WRITE, ADDR_X, 16'h0F0F, rd);
        read_check(CMD_READ_RESTORE, ADDR_W, 16'hAB34);
        read_check(CMD_READ_RESTORE, ADDR_X | 18'h00001, 16'h0F0F);
        repeat (20) @(posedge sys_clk);
        #1;
        check_word("idle data lines", 16'hFFFF, bus_a.data_n);
        check_bit("idle master sync", 1'b1, bus_a.master_sync_n);
        // Second bus: foreign block, then a start held off by power low.
        b_start(ADDR_F, CMD_CLEAR_WRITE);
        b_silent("foreign block ignored");
        b_stop();
        bus_b.supply_power_low_n = 1'b0;
        b_start(ADDR_W, CMD_CLEAR_WRITE);
        b_silent("power low inhibits");
        bus_b.supply_power_low_n = 1'b1;
        n = 0;
        while (bus_b.slave_sync_n !== 1'b0)
            tick(n, "start after power good");
        b_stop();
        check_bit("slave sync released", 1'b1, bus_b.slave_sync_n);
        check_bit("busy through write half", 1'b1, busy_b);
        // The next request lands while the write half still runs and must wait.
        b_start(ADDR_W, CMD_READ_RESTORE);
        check_bit("deferred start waits", 1'b1, bus_b.slave_sync_n);
        n = 0;
        while (bus_b.slave_sync_n !== 1'b0)
            tick(n, "deferred read answer");
        check_word("deferred read lines", ~16'h0F0F, bus_b.data_n);
        b_stop();
        repeat (20) @(posedge sys_clk);
        wrap_up();
    end
endmodule
`default_nettype wire
